// ---- rtl/rtee_pkg.sv ----
`default_nettype none
package rtee_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Event codes, vectors and offsets
  localparam int          EVT_W          = 12;
  localparam logic [11:0] EVT_POWER_ON   = 12'h000;
  localparam logic [11:0] EVT_MANUAL     = 12'h020;
  localparam logic [11:0] EVT_MULTI_HIT  = 12'h140;
  localparam logic [11:0] EVT_MISS_READ  = 12'h040;
  localparam logic [11:0] EVT_MISS_WRITE = 12'h060;
  localparam logic [11:0] EVT_INSTRUCTION_TRANSLATION_BUFFER_MISS  = 12'h040;
  localparam logic [11:0] EVT_INIT_WRITE = 12'h080;
  localparam logic [11:0] EVT_PROT_READ  = 12'h0a0;
  localparam logic [11:0] EVT_PROT_WRITE = 12'h0c0;
  localparam logic [31:0] RESET_VECTOR   = 32'ha0000000;
  localparam logic [31:0] OFS_TLB_MISS   = 32'h00000400;
  localparam logic [31:0] OFS_GENERAL    = 32'h00000100;

  ////////////////////////////////////////////////////////////////////////////
  // Status, page entry and configuration layout
  localparam int          SR_BL          = 28;
  localparam int          SR_RB          = 29;
  localparam int          SR_MD          = 30;
  localparam logic [31:0] SR_RESET       = 32'h700000f0;
  localparam logic [31:0] VBR_RESET      = 32'h00000000;
  localparam logic [31:0] CFG_RESET      = 32'h00000000;
  localparam int          CFG_EXT_BIT    = 0;
  localparam int          VPN_LSB        = 10;
  localparam logic [3:0]  DBG_TI_NEGATE  = 4'h6;
  localparam logic [3:0]  DBG_TI_ASSERT  = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  ADDR_EVENT     = 8'h00;
  localparam logic [7:0]  ADDR_FAULT     = 8'h04;
  localparam logic [7:0]  ADDR_PAGE_HI   = 8'h08;
  localparam logic [7:0]  ADDR_SAVED_PC  = 8'h0c;
  localparam logic [7:0]  ADDR_SAVED_SR  = 8'h10;
  localparam logic [7:0]  ADDR_SAVED_R15 = 8'h14;
  localparam logic [7:0]  ADDR_STATUS    = 8'h18;
  localparam logic [7:0]  ADDR_VBASE     = 8'h1c;
  localparam logic [7:0]  ADDR_CONFIG    = 8'h20;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    K_NONE    = 2'b00,
    K_GENERAL = 2'b01,
    K_MANUAL  = 2'b11,
    K_POWER   = 2'b10
  } rtee_kind_e;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] pc;
    logic        cache_block_invalidate_op;
    logic        multi;
    logic        miss;
    logic        pr;
    logic [5:0]  extended_protection_field;
  } rtee_fetch_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] pc;
    logic        write;
    logic        multi;
    logic        miss;
    logic        dirty;
    logic [1:0]  pr;
    logic [5:0]  extended_protection_field;
  } rtee_data_s;

endpackage
`default_nettype wire

// ---- rtl/rtee_top.sv ----
// Contract
// - Power-on reset: event code 000, full init, fetch from fixed reset vector.
// - Manual reset: event code 020, init core, branch to reset vector.
// - Manual reset inits a smaller register set; others keep their current values.
// - Debug reset instruction 0110/0111: code 000, init vector base, status, go reset vector.
// - Instruction TLB multiple hit: code 140, manual-style init, reset vector.
// - Data TLB multiple hit: same reset path, code 140.
// - TLB events capture fault address and page number, keep address space id.
// - General exception saves PC, status and R15.
// - General exception sets block, privileged and bank status bits.
// - Data TLB miss: code 040 read or 060 write, vector base plus 400.
// - Instruction TLB miss: code 40, vector base plus 400.
// - Store to clean page: code 080, vector base plus 100.
// - Data protection violation: code 0A0 read, 0C0 write, vector base plus 100.
// - Compatible mode data protection decoding of two-bit field.
// - Extended mode data deny bits 5,4,2,1.
// - Compatible mode fetch bit: 0 privileged only, 1 both modes.
// - Extended mode fetch pairs: 11 execute, 01 execute in user mode only, 10 invalidate only, 00 blocked.
// - Fetch protection violation: code 0A0, vector base plus 100.
// - Event code written into bits 11:0 of event register.
// - Simultaneous events accepted by level, then order.
`timescale 1ns/1ps
`default_nettype none
module rtee_top (
  // Clock and reset
  input  wire logic                 I_CLOCK,
  input  wire logic                 I_RSTN,
  // Reset and debug requests
  input  wire logic                 I_MANUAL_RESET,
  input  wire logic                 I_DBG_VALID,
  input  wire logic [7:0]           I_DBG_INSTR,
  // Pipeline and translation results
  input  wire rtee_pkg::rtee_fetch_s I_FETCH,
  input  wire rtee_pkg::rtee_data_s  I_DATA,
  input  wire logic [31:0]          I_R15,
  // Redirect to pipeline
  output var  logic                 O_REDIRECT,
  output var  logic [31:0]          O_REDIRECT_PC,
  output var  logic                 O_CORE_INIT,
  output var  logic                 O_INIT_POWER_ON,
  output var  logic [31:0]          O_STATUS,
  // AXI4-Lite write
  input  wire logic [7:0]           I_AWADDR,
  input  wire logic                 I_AWVALID,
  output var  logic                 O_AWREADY,
  input  wire logic [31:0]          I_WDATA,
  input  wire logic [3:0]           I_WSTRB,
  input  wire logic                 I_WVALID,
  output var  logic                 O_WREADY,
  output var  logic [1:0]           O_BRESP,
  output var  logic                 O_BVALID,
  input  wire logic                 I_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]           I_ARADDR,
  input  wire logic                 I_ARVALID,
  output var  logic                 O_ARREADY,
  output var  logic [31:0]          O_RDATA,
  output var  logic [1:0]           O_RRESP,
  output var  logic                 O_RVALID,
  input  wire logic                 I_RREADY
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic fetch_denied(input logic ext, input logic pr, input logic [5:0] extended_protection_field,
                                        input logic md, input logic cache_block_invalidate_op);
    logic [1:0] pair;
    pair = md ? {extended_protection_field[5], extended_protection_field[3]} : {extended_protection_field[2], extended_protection_field[0]};
    if (!ext) begin
      return md ? 1'b0 : ~pr;
    end
    if (pair == 2'b11 || (!md && pair == 2'b01)) begin
      return 1'b0;
    end
    if (pair == 2'b10) begin
      return ~cache_block_invalidate_op;
    end
    return 1'b1;
  endfunction

  function automatic logic data_denied(input logic ext, input logic [1:0] pr, input logic [5:0] extended_protection_field,
                                       input logic md, input logic wr);
    if (!ext) begin
      return md ? (wr & ~pr[0]) : (~pr[1] | (wr & ~pr[0]));
    end
    return md ? (wr ? extended_protection_field[4] : extended_protection_field[5]) : (wr ? extended_protection_field[1] : extended_protection_field[2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [11:0] event_code_ff;
  logic [31:0] fault_address_reg_ff;
  logic [31:0] page_entry_high_reg_ff;
  logic [31:0] saved_pc_ff;
  logic [31:0] saved_status_ff;
  logic [31:0] saved_stack_reg_ff;
  logic [31:0] status_reg_ff;
  logic [31:0] vector_base_reg_ff;
  logic [31:0] config_ff;
  logic        por_pending_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Event detection and priority
  logic        md;
  logic        ext;
  logic        dbg_reset;
  logic        f_multi, f_miss, f_prot;
  logic        d_multi, d_miss, d_prot, d_init;
  logic        gen_any;

  assign md        = status_reg_ff[rtee_pkg::SR_MD];
  assign ext       = config_ff[rtee_pkg::CFG_EXT_BIT];
  assign dbg_reset = I_DBG_VALID && (I_DBG_INSTR[7:4] == rtee_pkg::DBG_TI_NEGATE ||
                                     I_DBG_INSTR[7:4] == rtee_pkg::DBG_TI_ASSERT);
  assign f_multi   = I_FETCH.valid & I_FETCH.multi;
  assign f_miss    = I_FETCH.valid & ~I_FETCH.multi & I_FETCH.miss;
  assign f_prot    = I_FETCH.valid & ~I_FETCH.multi & ~I_FETCH.miss &
                     fetch_denied(ext, I_FETCH.pr, I_FETCH.extended_protection_field, md, I_FETCH.cache_block_invalidate_op);
  assign d_multi   = I_DATA.valid & I_DATA.multi;
  assign d_miss    = I_DATA.valid & ~I_DATA.multi & I_DATA.miss;
  assign d_prot    = I_DATA.valid & ~I_DATA.multi & ~I_DATA.miss &
                     data_denied(ext, I_DATA.pr, I_DATA.extended_protection_field, md, I_DATA.write);
  assign d_init    = I_DATA.valid & ~I_DATA.multi & ~I_DATA.miss & ~d_prot &
                     I_DATA.write & ~I_DATA.dirty;
  assign gen_any   = f_miss | f_prot | d_miss | d_prot | d_init;

  rtee_pkg::rtee_kind_e kind;
  logic [11:0]          code;
  logic [31:0]          target;
  logic                 capture;
  logic [31:0]          fault_addr;
  logic [31:0]          epc;

  always_comb begin
    kind       = rtee_pkg::K_NONE;
    code       = rtee_pkg::EVT_POWER_ON;
    target     = rtee_pkg::RESET_VECTOR;
    capture    = 1'b0;
    fault_addr = I_DATA.addr;
    epc        = I_DATA.pc;
    // Within a level, fetch events precede data events: the fetch belongs to an earlier pipeline slot
    if (por_pending_ff) begin
      kind = rtee_pkg::K_POWER;
      code = rtee_pkg::EVT_POWER_ON;
    end else if (dbg_reset) begin
      kind = rtee_pkg::K_MANUAL;
      code = rtee_pkg::EVT_POWER_ON;
    end else if (I_MANUAL_RESET) begin
      kind = rtee_pkg::K_MANUAL;
      code = rtee_pkg::EVT_MANUAL;
    end else if (f_multi) begin
      kind       = rtee_pkg::K_MANUAL;
      code       = rtee_pkg::EVT_MULTI_HIT;
      capture    = 1'b1;
      fault_addr = I_FETCH.addr;
    end else if (d_multi) begin
      kind    = rtee_pkg::K_MANUAL;
      code    = rtee_pkg::EVT_MULTI_HIT;
      capture = 1'b1;
    end else if (gen_any && status_reg_ff[rtee_pkg::SR_BL]) begin
      // A general exception while blocked cannot be handled safely; fall back to manual reset
      kind = rtee_pkg::K_MANUAL;
      code = rtee_pkg::EVT_MANUAL;
    end else if (gen_any) begin
      kind    = rtee_pkg::K_GENERAL;
      capture = 1'b1;
      target  = vector_base_reg_ff + rtee_pkg::OFS_GENERAL;
      if (f_miss || f_prot) begin
        fault_addr = I_FETCH.addr;
        epc        = I_FETCH.pc;
      end
      if (f_miss) begin
        code   = rtee_pkg::EVT_INSTRUCTION_TRANSLATION_BUFFER_MISS;
        target = vector_base_reg_ff + rtee_pkg::OFS_TLB_MISS;
      end else if (f_prot) begin
        code = rtee_pkg::EVT_PROT_READ;
      end else if (d_miss) begin
        code   = I_DATA.write ? rtee_pkg::EVT_MISS_WRITE : rtee_pkg::EVT_MISS_READ;
        target = vector_base_reg_ff + rtee_pkg::OFS_TLB_MISS;
      end else if (d_prot) begin
        code = I_DATA.write ? rtee_pkg::EVT_PROT_WRITE : rtee_pkg::EVT_PROT_READ;
      end else begin
        code = rtee_pkg::EVT_INIT_WRITE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic        aw_hold_ff, w_hold_ff;
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        do_wr;
  logic        aw_take, w_take, ar_take;
  logic        nxt_aw_hold, nxt_w_hold, nxt_rvalid;

  assign aw_take     = I_AWVALID & O_AWREADY;
  assign w_take      = I_WVALID & O_WREADY;
  assign ar_take     = I_ARVALID & O_ARREADY;
  assign do_wr       = aw_hold_ff & w_hold_ff & ~O_BVALID;
  assign nxt_aw_hold = do_wr ? 1'b0 : (aw_hold_ff | aw_take);
  assign nxt_w_hold  = do_wr ? 1'b0 : (w_hold_ff | w_take);
  assign nxt_rvalid  = ar_take | (O_RVALID & ~I_RREADY);

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] reg_addr, input logic go);
    return go && (a == reg_addr);
  endfunction

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
      O_AWREADY  <= 1'b1;
      O_WREADY   <= 1'b1;
      O_BVALID   <= 1'b0;
      O_BRESP    <= rtee_pkg::RESP_OKAY;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff  <= nxt_w_hold;
      O_AWREADY  <= ~nxt_aw_hold;
      O_WREADY   <= ~nxt_w_hold;
      if (aw_take) begin
        aw_addr_ff <= I_AWADDR;
      end
      if (w_take) begin
        w_data_ff <= I_WDATA;
        w_strb_ff <= I_WSTRB;
      end
      if (do_wr) begin
        O_BVALID <= 1'b1;
        case (aw_addr_ff)
          rtee_pkg::ADDR_FAULT, rtee_pkg::ADDR_PAGE_HI, rtee_pkg::ADDR_STATUS,
          rtee_pkg::ADDR_VBASE, rtee_pkg::ADDR_CONFIG: O_BRESP <= rtee_pkg::RESP_OKAY;
          default: O_BRESP <= rtee_pkg::RESP_SLVERR;
        endcase
      end else if (I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_ARREADY <= 1'b1;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h00000000;
      O_RRESP   <= rtee_pkg::RESP_OKAY;
    end else begin
      O_RVALID  <= nxt_rvalid;
      O_ARREADY <= ~nxt_rvalid;
      if (ar_take) begin
        O_RRESP <= rtee_pkg::RESP_OKAY;
        case (I_ARADDR)
          rtee_pkg::ADDR_EVENT:     O_RDATA <= {20'h00000, event_code_ff};
          rtee_pkg::ADDR_FAULT:     O_RDATA <= fault_address_reg_ff;
          rtee_pkg::ADDR_PAGE_HI:   O_RDATA <= page_entry_high_reg_ff;
          rtee_pkg::ADDR_SAVED_PC:  O_RDATA <= saved_pc_ff;
          rtee_pkg::ADDR_SAVED_SR:  O_RDATA <= saved_status_ff;
          rtee_pkg::ADDR_SAVED_R15: O_RDATA <= saved_stack_reg_ff;
          rtee_pkg::ADDR_STATUS:    O_RDATA <= status_reg_ff;
          rtee_pkg::ADDR_VBASE:     O_RDATA <= vector_base_reg_ff;
          rtee_pkg::ADDR_CONFIG:    O_RDATA <= config_ff;
          default: begin
            O_RDATA <= 32'h00000000;
            O_RRESP <= rtee_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exception commit; hardware updates win over a software write in the same cycle
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      por_pending_ff  <= 1'b1;
      O_REDIRECT      <= 1'b0;
      O_REDIRECT_PC   <= rtee_pkg::RESET_VECTOR;
      O_CORE_INIT     <= 1'b0;
      O_INIT_POWER_ON <= 1'b0;
      event_code_ff   <= rtee_pkg::EVT_POWER_ON;
    end else begin
      por_pending_ff  <= 1'b0;
      O_REDIRECT      <= (kind != rtee_pkg::K_NONE);
      O_REDIRECT_PC   <= target;
      O_CORE_INIT     <= (kind == rtee_pkg::K_POWER) || (kind == rtee_pkg::K_MANUAL);
      O_INIT_POWER_ON <= (kind == rtee_pkg::K_POWER);
      if (kind != rtee_pkg::K_NONE) begin
        event_code_ff <= code[rtee_pkg::EVT_W-1:0];
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      fault_address_reg_ff   <= 32'h00000000;
      page_entry_high_reg_ff <= 32'h00000000;
    end else if (capture) begin
      fault_address_reg_ff <= fault_addr;
      page_entry_high_reg_ff[31:rtee_pkg::VPN_LSB] <= fault_addr[31:rtee_pkg::VPN_LSB];
    end else begin
      if (wr_hit(aw_addr_ff, rtee_pkg::ADDR_FAULT, do_wr)) begin
        fault_address_reg_ff <= merge_strb(fault_address_reg_ff, w_data_ff, w_strb_ff);
      end
      if (wr_hit(aw_addr_ff, rtee_pkg::ADDR_PAGE_HI, do_wr)) begin
        page_entry_high_reg_ff <= merge_strb(page_entry_high_reg_ff, w_data_ff, w_strb_ff);
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      saved_pc_ff        <= 32'h00000000;
      saved_status_ff    <= 32'h00000000;
      saved_stack_reg_ff <= 32'h00000000;
    end else if (kind == rtee_pkg::K_GENERAL) begin
      saved_pc_ff        <= epc;
      saved_status_ff    <= status_reg_ff;
      saved_stack_reg_ff <= I_R15;
    end
  end

  // Manual-class events reset status and vector base only; configuration survives
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      status_reg_ff      <= rtee_pkg::SR_RESET;
      vector_base_reg_ff <= rtee_pkg::VBR_RESET;
    end else if (kind == rtee_pkg::K_MANUAL) begin
      status_reg_ff      <= rtee_pkg::SR_RESET;
      vector_base_reg_ff <= rtee_pkg::VBR_RESET;
    end else if (kind == rtee_pkg::K_GENERAL) begin
      status_reg_ff[rtee_pkg::SR_BL] <= 1'b1;
      status_reg_ff[rtee_pkg::SR_MD] <= 1'b1;
      status_reg_ff[rtee_pkg::SR_RB] <= 1'b1;
    end else begin
      if (wr_hit(aw_addr_ff, rtee_pkg::ADDR_STATUS, do_wr)) begin
        status_reg_ff <= merge_strb(status_reg_ff, w_data_ff, w_strb_ff);
      end
      if (wr_hit(aw_addr_ff, rtee_pkg::ADDR_VBASE, do_wr)) begin
        vector_base_reg_ff <= merge_strb(vector_base_reg_ff, w_data_ff, w_strb_ff);
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      config_ff <= rtee_pkg::CFG_RESET;
    end else if (wr_hit(aw_addr_ff, rtee_pkg::ADDR_CONFIG, do_wr)) begin
      config_ff <= merge_strb(config_ff, w_data_ff, w_strb_ff);
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_STATUS <= rtee_pkg::SR_RESET;
    end else begin
      O_STATUS <= status_reg_ff;
    end
  end

endmodule // rtee_top
`default_nettype wire

// ---- test/rtee_top_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtee_top_assertions (
  // Clock and reset
  input wire logic                  I_CLOCK,
  input wire logic                  I_RSTN,
  // Event sources
  input wire logic                  I_MANUAL_RESET,
  input wire logic                  I_DBG_VALID,
  input wire logic [7:0]            I_DBG_INSTR,
  input wire rtee_pkg::rtee_fetch_s I_FETCH,
  input wire rtee_pkg::rtee_data_s  I_DATA,
  // Redirect side
  input wire logic                  O_REDIRECT,
  input wire logic [31:0]           O_REDIRECT_PC,
  input wire logic                  O_CORE_INIT,
  input wire logic                  O_INIT_POWER_ON,
  input wire logic [31:0]           O_STATUS,
  // Bus answers
  input wire logic                  O_BVALID,
  input wire logic [1:0]            O_BRESP,
  input wire logic                  I_BREADY,
  input wire logic                  O_RVALID,
  input wire logic [31:0]           O_RDATA,
  input wire logic                  I_RREADY
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);
  // The first edge after release belongs to the power-on event
  logic seen_ff;
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) seen_ff <= 1'b0;
    else seen_ff <= 1'b1;
  end
  ////////////////////////////////////////
  a_init_vector: assert property (O_CORE_INIT |-> O_REDIRECT && O_REDIRECT_PC == rtee_pkg::RESET_VECTOR)
    else $error("reset class redirect off vector");
  a_power_in_init: assert property (O_INIT_POWER_ON |-> O_CORE_INIT)
    else $error("power-on without core init");
  a_manual_init: assert property (seen_ff && I_MANUAL_RESET |=> O_CORE_INIT && !O_INIT_POWER_ON)
    else $error("manual reset not taken");
  a_debug_init: assert property (seen_ff && I_DBG_VALID && I_DBG_INSTR[7:5] == 3'b011 |=> O_CORE_INIT)
    else $error("debug reset not taken");
  a_fetch_multi: assert property (seen_ff && I_FETCH.valid && I_FETCH.multi |=> O_CORE_INIT)
    else $error("fetch multiple hit not reset class");
  a_data_multi: assert property (seen_ff && I_DATA.valid && I_DATA.multi |=> O_CORE_INIT)
    else $error("data multiple hit not reset class");
  a_miss_bits: assert property (seen_ff && (I_FETCH.valid && I_FETCH.miss || I_DATA.valid && I_DATA.miss)
    |=> O_REDIRECT ##1 O_STATUS[30:28] == 3'b111)
    else $error("miss left status bits clear");
  a_idle_quiet: assert property (seen_ff && !I_FETCH.valid && !I_DATA.valid && !I_MANUAL_RESET &&
    !I_DBG_VALID |=> !O_REDIRECT)
    else $error("redirect without cause");
  a_bresp_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  a_rdata_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped");
  c_general: cover property (O_REDIRECT && !O_CORE_INIT);
  c_manual: cover property (I_MANUAL_RESET);
  c_write: cover property (O_BVALID && I_BREADY);
endmodule // rtee_top_assertions

bind rtee_top rtee_top_assertions u_chk (
  .I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN), .I_MANUAL_RESET(I_MANUAL_RESET), .I_DBG_VALID(I_DBG_VALID),
  .I_DBG_INSTR(I_DBG_INSTR), .I_FETCH(I_FETCH), .I_DATA(I_DATA), .O_REDIRECT(O_REDIRECT),
  .O_REDIRECT_PC(O_REDIRECT_PC), .O_CORE_INIT(O_CORE_INIT), .O_INIT_POWER_ON(O_INIT_POWER_ON),
  .O_STATUS(O_STATUS), .O_BVALID(O_BVALID), .O_BRESP(O_BRESP), .I_BREADY(I_BREADY),
  .O_RVALID(O_RVALID), .O_RDATA(O_RDATA), .I_RREADY(I_RREADY)
);
`default_nettype wire

// ---- test/rtee_pipe_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtee_pipe_model (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  // Command from the bench
  input  wire logic                  i_req,
  input  wire logic [3:0]            i_sel,
  input  wire logic [31:0]           i_addr,
  input  wire logic [31:0]           i_pc,
  // Translation results
  output var  rtee_pkg::rtee_fetch_s o_fetch,
  output var  rtee_pkg::rtee_data_s  o_data
);
  // Idle fields keep toggling so a stale value never passes for a request
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fetch <= '0;
      o_data  <= '0;
    end else if (i_req) begin
      o_fetch <= {i_sel inside {2, 6, 7, 9}, i_addr, i_pc, 1'b0, i_sel == 7, i_sel inside {2, 9},
                  i_sel != 6, 5'h1f, i_sel != 6};
      o_data  <= {i_sel inside {0, 1, 3, 4, 5, 8, 9, 10}, ~i_addr, ~i_pc, i_sel inside {1, 3, 5}, i_sel == 8,
                  i_sel inside {0, 1, 9}, i_sel != 3, i_sel inside {4, 5} ? 2'b00 : 2'b11,
                  i_sel == 10 ? 6'h20 : 6'h00};
    end else begin
      o_fetch       <= ~o_fetch;
      o_data        <= ~o_data;
      o_fetch.valid <= 1'b0;
      o_data.valid  <= 1'b0;
    end
  end
endmodule // rtee_pipe_model
`default_nettype wire

// ---- test/reset_and_tlb_exception_entry_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module reset_and_tlb_exception_entry_bench;
  logic                  clk, rst_n, man, dv, preq, awvalid, wvalid, bready, arvalid, rready;
  logic                  redir, cinit, pinit, awready, wready, bvalid, arready, rvalid;
  logic [7:0]            di, awaddr, araddr, address_space_id;
  logic [3:0]            wstrb, psel;
  logic [1:0]            bresp, rresp, rr;
  logic [31:0]           r15, wdata, pa, pp, rpc, status, rdata, v, vb, a, p, rv, sr0, fa, seed;
  rtee_pkg::rtee_fetch_s fe;
  rtee_pkg::rtee_data_s  da;
  int                    fail_count, n_compared, s;
  localparam logic [11:0] CODES [15] = '{12'h040, 12'h060, 12'h040, 12'h080, 12'h0a0, 12'h0c0, 12'h0a0,
    12'h140, 12'h140, 12'h040, 12'h0a0, 12'h020, 12'h000, 12'h000, 12'h020};
  rtee_top DUT (
    .I_CLOCK(clk), .I_RSTN(rst_n), .I_MANUAL_RESET(man), .I_DBG_VALID(dv), .I_DBG_INSTR(di),
    .I_FETCH(fe), .I_DATA(da), .I_R15(r15), .O_REDIRECT(redir), .O_REDIRECT_PC(rpc),
    .O_CORE_INIT(cinit), .O_INIT_POWER_ON(pinit), .O_STATUS(status),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_RVALID(rvalid), .I_RREADY(rready)
  );
  rtee_pipe_model u_pipe (
    .i_clk(clk), .i_rst_n(rst_n), .i_req(preq), .i_sel(psel), .i_addr(pa), .i_pc(pp), .o_fetch(fe), .o_data(da)
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic rcls(int k);
    return k inside {7, 8, 11, 12, 13, 14};
  endfunction
  function automatic logic fsrc(int k);
    return k inside {2, 6, 7, 9};
  endfunction
  function automatic logic [31:0] epc(int k, logic [31:0] b);
    return rcls(k) ? rtee_pkg::RESET_VECTOR : b + (k inside {0, 1, 2, 9} ? rtee_pkg::OFS_TLB_MISS : rtee_pkg::OFS_GENERAL);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data go out together; each is dropped once its own ready is seen
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      ta = ta | awready;
      tw = tw | wready;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(posedge clk); while (!bvalid);
    chk(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] ad);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    v = rdata;
    rr = rresp;
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    {rst_n, man, dv, preq, awvalid, wvalid, bready, arvalid, rready} = '0;
    {di, awaddr, araddr, psel, r15, wdata, pa, pp} = '0;
    wstrb = 4'hf;
    fail_count = 0;
    n_compared = 0;
    seed = 32'h00017185;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk({29'h0, redir, cinit, pinit}, 32'h7);
    chk(rpc, rtee_pkg::RESET_VECTOR);
    rd(rtee_pkg::ADDR_EVENT);
    chk(v, 32'h0);
    rd(rtee_pkg::ADDR_STATUS);
    chk(v, rtee_pkg::SR_RESET);
    rd(8'h40);
    chk({v[29:0], rr}, {30'h0, rtee_pkg::RESP_SLVERR});
    wr(rtee_pkg::ADDR_SAVED_PC, 32'h1, rtee_pkg::RESP_SLVERR);
    for (int k = 0; k < 30; k++) begin
      s = k % 15;
      vb = rnd();
      a = rnd();
      p = rnd();
      rv = rnd();
      address_space_id = 8'(rnd());
      sr0 = {1'b0, !(s inside {4, 6}), 1'b0, s == 14, 28'h00000f0};
      r15 <= rv;
      wr(rtee_pkg::ADDR_CONFIG, {31'h0, s inside {10, 11} || k == 21}, rtee_pkg::RESP_OKAY);
      wr(rtee_pkg::ADDR_VBASE, vb, rtee_pkg::RESP_OKAY);
      wr(rtee_pkg::ADDR_PAGE_HI, {24'h0, address_space_id}, rtee_pkg::RESP_OKAY);
      wr(rtee_pkg::ADDR_STATUS, sr0, rtee_pkg::RESP_OKAY);
      pa <= a;
      pp <= p;
      if (s == 11) man <= 1'b1;
      else if (s inside {12, 13}) begin
        dv <= 1'b1;
        di <= {s == 12 ? 4'h6 : 4'h7, 4'(rnd())};
      end else begin
        preq <= 1'b1;
        psel <= s == 14 ? 4'h0 : 4'(s);
      end
      @(posedge clk);
      {man, dv, preq} <= 3'b000;
      do @(posedge clk); while (!redir);
      chk(rpc, epc(s, vb));
      chk(32'(cinit), 32'(rcls(s)));
      rd(rtee_pkg::ADDR_EVENT);
      chk(v, {20'h0, CODES[s]});
      rd(rtee_pkg::ADDR_STATUS);
      chk(v, rcls(s) ? rtee_pkg::SR_RESET : sr0 | 32'h70000000);
      if (s <= 10) begin
        fa = fsrc(s) ? a : ~a;
        rd(rtee_pkg::ADDR_FAULT);
        chk(v, fa);
        rd(rtee_pkg::ADDR_PAGE_HI);
        chk({v[31:10], 2'b00, v[7:0]}, {fa[31:10], 2'b00, address_space_id});
      end
      if (!rcls(s)) begin
        rd(rtee_pkg::ADDR_SAVED_PC);
        chk(v, fsrc(s) ? p : ~p);
        rd(rtee_pkg::ADDR_SAVED_SR);
        chk(v, sr0);
        rd(rtee_pkg::ADDR_SAVED_R15);
        chk(v, rv);
      end else begin
        rd(rtee_pkg::ADDR_VBASE);
        chk(v, rtee_pkg::VBR_RESET);
        rd(rtee_pkg::ADDR_CONFIG);
        chk(v, {31'h0, s == 11});
      end
    end
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule // reset_and_tlb_exception_entry_bench
`default_nettype wire
